// ===== pkg/mtc_pkg.sv
// constants for the measurement trigger control block
// Notes on behaviour
// - immediate force fires, completes on acceptance
// - single force fires, completes after sweep
// - force outside trigger wait: error, ignored
// - point-trigger enable, readable, off after reset
// - internal source ignores point-trigger enable
// - external trigger delay, 10 us steps
// - external edge polarity selectable, negative default
// - four trigger origins, internal default
// - internal origin triggers continuously by itself
// - external edge on connector or handler
// - manual key fires a trigger
// - bus trigger command fires a trigger
// - origin change during sweep aborts sweep
// - channel scope all or active only
// - active channel change moves continuous measurement
package mtc_pkg;
  // -------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL     = 5'h00;
  localparam logic [4:0] OFF_DELAY    = 5'h04;
  localparam logic [4:0] OFF_CMD      = 5'h08;
  localparam logic [4:0] OFF_STATUS   = 5'h0C;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h10;
  localparam logic [4:0] OFF_IRQ_EN   = 5'h14;
  localparam logic [4:0] OFF_IRQ_CLR  = 5'h18;
  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int CTRL_SRC_LO = 0;
  localparam int CTRL_POL    = 2;
  localparam int CTRL_POINT  = 3;
  localparam int CTRL_SCOPE  = 4;
  localparam int CTRL_CONT   = 5;
  localparam int CTRL_W      = 6;
  localparam int CMD_IMM     = 0;
  localparam int CMD_SINGLE  = 1;
  localparam int CMD_BUSTRG  = 2;
  localparam int CMD_INIT    = 3;
  localparam int ST_WAIT_B   = 0;
  localparam int ST_BUSY_B   = 1;
  localparam int ST_DLY_B    = 2;
  localparam int ST_SPEND_B  = 3;
  localparam int EV_FIRE     = 0;
  localparam int EV_SWEEP    = 1;
  localparam int EV_ERR      = 2;
  localparam int EV_IMM      = 3;
  localparam int EV_SINGLE   = 4;
  localparam int EV_W        = 5;
  localparam int DLY_W       = 20;
  // -------------------------------------------------------------------
  // encodings and reset values
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_MAN, SRC_BUS} mtc_src_t;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 6'h00;
  localparam logic [DLY_W-1:0]  DLY_RST   = 20'h0_0000;
  localparam logic [DLY_W-1:0]  DLY_MAX   = 20'hF_4240;
  localparam logic [EV_W-1:0]   EV_RST    = 5'h00;
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_PS      = 4000;
  localparam int DLY_STEP_PS = 10000000;
  localparam int STEP_CYC    = DLY_STEP_PS / CLK_PS;
endpackage

// ===== rtl/mtc_trigger.sv
// trigger control core with avalon register slave
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
module mtc_trigger #(
  parameter int N_CH     = 4,
  parameter int CH_W     = 2,
  parameter int STEP_CYC = mtc_pkg::STEP_CYC
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic [4:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   ext_trig_in,
  input  wire logic                   handler_trig_in,
  input  wire logic                   manual_key,
  input  wire logic                   point_done,
  input  wire logic                   sweep_done,
  input  wire logic [CH_W-1:0]        active_channel,
  output logic                        meas_start,
  output logic                        meas_point_mode,
  output logic                        sweep_abort,
  output logic      [N_CH-1:0]        chan_mask,
  output logic                        irq
);
  import mtc_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_DELAY, S_MEAS} mtc_state_t;

  // -------------------------------------------------------------------
  // bus slave
  // -------------------------------------------------------------------
  logic                    ack;
  logic [CTRL_W-1:0]       ctrl;
  logic [DLY_W-1:0]        dly;
  logic [EV_W-1:0]         irq_stat;
  logic [EV_W-1:0]         irq_en;
  mtc_state_t              state;
  mtc_state_t              next_state;
  logic                    single_pend;
  logic [31:0]             next_rdata;
  wire                     acc     = (avs_read | avs_write) & ~ack;
  wire                     wr      = avs_write & ack;
  wire                     wr_ctrl = wr & (avs_address == OFF_CTRL);
  wire                     wr_cmd  = wr & (avs_address == OFF_CMD);
  wire mtc_src_t           src     = mtc_src_t'(ctrl[CTRL_SRC_LO +: 2]);
  wire mtc_src_t           new_src = mtc_src_t'(avs_writedata[CTRL_SRC_LO +: 2]);
  wire                     trig_wait = (state == S_WAIT);
  wire                     busy    = (state == S_DELAY) | (state == S_MEAS);
  wire [3:0]               status  = {single_pend, state == S_DELAY, busy, trig_wait};

  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  always_comb begin
    case (avs_address)
      OFF_CTRL:     next_rdata = 32'(ctrl);
      OFF_DELAY:    next_rdata = 32'(dly);
      OFF_STATUS:   next_rdata = 32'(status);
      OFF_IRQ_STAT: next_rdata = 32'(irq_stat);
      OFF_IRQ_EN:   next_rdata = 32'(irq_en);
      default:      next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack          <= acc;
      if (acc && avs_read) begin
        avs_readdata <= next_rdata;
      end
    end
  end

  // settings: source, polarity, point, scope, continuous, delay
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl   <= CTRL_RST;
      dly    <= DLY_RST;
      irq_en <= EV_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= avs_writedata[CTRL_W-1:0];
      end
      if (wr && avs_address == OFF_DELAY) begin
        dly <= (avs_writedata[DLY_W-1:0] > DLY_MAX) ? DLY_MAX : avs_writedata[DLY_W-1:0];
      end
      if (wr && avs_address == OFF_IRQ_EN) begin
        irq_en <= avs_writedata[EV_W-1:0];
      end
    end
  end

  // -------------------------------------------------------------------
  // trigger event detection
  // -------------------------------------------------------------------
  logic                    ext_q;
  logic                    hnd_q;
  logic                    key_q;
  logic [CH_W-1:0]         chan_q;
  wire                     pos     = ctrl[CTRL_POL];
  wire                     ext_e   = pos ? (ext_trig_in & ~ext_q) : (~ext_trig_in & ext_q);
  wire                     hnd_e   = pos ? (handler_trig_in & ~hnd_q)
                                         : (~handler_trig_in & hnd_q);
  wire                     ext_hit = ext_e | hnd_e;
  wire                     key_hit = manual_key & ~key_q;
  wire                     cmd_imm = wr_cmd & avs_writedata[CMD_IMM];
  wire                     cmd_sgl = wr_cmd & avs_writedata[CMD_SINGLE];
  wire                     frc_any = cmd_imm | cmd_sgl;
  wire                     bus_trg = wr_cmd & avs_writedata[CMD_BUSTRG];
  wire                     src_hit = (src == SRC_INT)
                                   | ((src == SRC_EXT) & ext_hit)
                                   | ((src == SRC_MAN) & key_hit)
                                   | ((src == SRC_BUS) & bus_trg);
  wire                     fire    = trig_wait & (frc_any | src_hit);
  wire                     bad_frc = frc_any & ~trig_wait;
  wire                     go_dly  = fire & ~frc_any & (src == SRC_EXT) & (dly != DLY_RST);
  wire                     point_eff = ctrl[CTRL_POINT] & (src != SRC_INT);
  wire                     src_chg = wr_ctrl & (new_src != src) & busy;
  wire                     ch_chg  = (active_channel != chan_q) & ctrl[CTRL_SCOPE]
                                   & ctrl[CTRL_CONT] & busy;
  wire                     abort   = src_chg | ch_chg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_q  <= 1'b0;
      hnd_q  <= 1'b0;
      key_q  <= 1'b0;
      chan_q <= '0;
    end else begin
      ext_q  <= ext_trig_in;
      hnd_q  <= handler_trig_in;
      key_q  <= manual_key;
      chan_q <= active_channel;
    end
  end

  // -------------------------------------------------------------------
  // external delay timer, one step per 10 us tick
  // -------------------------------------------------------------------
  logic [31:0]             tick;
  logic [DLY_W-1:0]        steps;
  wire                     tick_end = (tick == 32'(STEP_CYC - 1));
  wire                     dly_end  = (state == S_DELAY) & tick_end & (steps == DLY_W'(1));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tick  <= 32'h0000_0000;
      steps <= DLY_RST;
    end else if (go_dly) begin
      tick  <= 32'h0000_0000;
      steps <= dly;
    end else if (state == S_DELAY) begin
      tick  <= tick_end ? 32'h0000_0000 : tick + 32'h0000_0001;
      steps <= tick_end ? steps - DLY_W'(1) : steps;
    end
  end

  // -------------------------------------------------------------------
  // trigger sequencer
  // -------------------------------------------------------------------
  wire                     start = (fire & ~go_dly) | (dly_end & ~abort);
  wire                     sw_end = (state == S_MEAS) & sweep_done & ~abort;
  wire                     rearm = ctrl[CTRL_CONT] | (wr_cmd & avs_writedata[CMD_INIT]);

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE:  next_state = rearm ? S_WAIT : S_IDLE;
      S_WAIT:  next_state = go_dly ? S_DELAY : (fire ? S_MEAS : S_WAIT);
      S_DELAY: next_state = abort ? S_WAIT : (dly_end ? S_MEAS : S_DELAY);
      S_MEAS: begin
        if (abort) begin
          next_state = S_WAIT;
        end else if (sweep_done) begin
          next_state = ctrl[CTRL_CONT] ? S_WAIT : S_IDLE;
        end else if (point_done && point_eff) begin
          next_state = S_WAIT;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state       <= S_IDLE;
      single_pend <= 1'b0;
    end else begin
      state       <= next_state;
      if (fire && cmd_sgl) begin
        single_pend <= 1'b1;
      end else if (sw_end || abort) begin
        single_pend <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // outputs to the measurement engine
  // -------------------------------------------------------------------
  wire [N_CH-1:0]          act_mask = N_CH'(1) << active_channel;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meas_start      <= 1'b0;
      meas_point_mode <= 1'b0;
      sweep_abort     <= 1'b0;
      chan_mask       <= '1;
    end else begin
      meas_start      <= start;
      meas_point_mode <= point_eff;
      sweep_abort     <= abort;
      chan_mask       <= ctrl[CTRL_SCOPE] ? act_mask : '1;
    end
  end

  // -------------------------------------------------------------------
  // interrupt status: set wins over clear
  // -------------------------------------------------------------------
  logic [EV_W-1:0]         ev;
  wire  [EV_W-1:0]         clr = (wr && avs_address == OFF_IRQ_CLR) ? avs_writedata[EV_W-1:0]
                                                                    : EV_RST;

  always_comb begin
    ev           = EV_RST;
    ev[EV_FIRE]  = start;
    ev[EV_SWEEP] = sw_end;
    ev[EV_ERR]   = bad_frc;
    ev[EV_IMM]   = fire & cmd_imm;
    ev[EV_SINGLE] = sw_end & single_pend;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat <= EV_RST;
    end else begin
      irq_stat <= (irq_stat & ~clr) | ev;
    end
  end

  assign irq = |(irq_stat & irq_en);

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  sequence s_bad_force;
    frc_any && !trig_wait && !dly_end;
  endsequence
  sequence s_ok_imm;
    cmd_imm && trig_wait;
  endsequence

  property p_force_err;
    @(posedge clk_sys) disable iff (!reset_n) s_bad_force |=> irq_stat[EV_ERR] && !meas_start;
  endproperty
  a_force_err: assert property (p_force_err) else $error("bad force not flagged");

  property p_imm_done;
    @(posedge clk_sys) disable iff (!reset_n) s_ok_imm |=> meas_start && irq_stat[EV_IMM];
  endproperty
  a_imm_done: assert property (p_imm_done) else $error("immediate force not done");

  property p_single_hold;
    @(posedge clk_sys) disable iff (!reset_n)
      (cmd_sgl && trig_wait) |=> single_pend && !irq_stat[EV_SINGLE];
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("single done too early");

  property p_int_auto;
    @(posedge clk_sys) disable iff (!reset_n) (trig_wait && src == SRC_INT) |=> meas_start;
  endproperty
  a_int_auto: assert property (p_int_auto) else $error("internal trigger missing");

  property p_point_int;
    @(posedge clk_sys) disable iff (!reset_n) (src == SRC_INT) ##1 (src == SRC_INT) |-> !meas_point_mode;
  endproperty
  a_point_int: assert property (p_point_int) else $error("point mode on internal");

  property p_src_abort;
    @(posedge clk_sys) disable iff (!reset_n) src_chg |=> sweep_abort && trig_wait;
  endproperty
  a_src_abort: assert property (p_src_abort) else $error("source change no abort");

  property p_ext_delay;
    @(posedge clk_sys) disable iff (!reset_n) go_dly |=> !meas_start [*2];
  endproperty
  a_ext_delay: assert property (p_ext_delay) else $error("delay skipped");

  property p_scope_all;
    @(posedge clk_sys) disable iff (!reset_n) !ctrl[CTRL_SCOPE] |=> chan_mask == {N_CH{1'b1}};
  endproperty
  a_scope_all: assert property (p_scope_all) else $error("scope all not all");

  property p_ext_edge;
    @(posedge clk_sys) disable iff (!reset_n)
      (trig_wait && src == SRC_EXT && !frc_any && dly == DLY_RST && ext_e) |=> meas_start;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("external edge missed");
endmodule

// ===== sim/mtc_engine_model.sv
// measurement engine model answering starts with point or sweep completion
`timescale 1ns/1ps
module mtc_engine_model (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       meas_start,
  input  wire logic       meas_point_mode,
  input  wire logic       sweep_abort,
  input  wire logic [7:0] latency,
  output logic            point_done,
  output logic            sweep_done
);
  // latency 0 stalls the engine until an abort
  logic [7:0] cnt;
  logic       pt;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt        <= 8'h00;
      pt         <= 1'b0;
      point_done <= 1'b0;
      sweep_done <= 1'b0;
    end else begin
      point_done <= 1'b0;
      sweep_done <= 1'b0;
      if (sweep_abort) begin
        cnt <= 8'h00;
      end else if (meas_start) begin
        cnt <= latency;
        pt  <= meas_point_mode;
      end else if (cnt == 8'h01) begin
        cnt        <= 8'h00;
        point_done <= pt;
        sweep_done <= !pt;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the trigger control block
`timescale 1ns/1ps
module tb_top;
  import mtc_pkg::*;
  localparam int STEP = 4;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ext_trig_in = 1'b0;
  logic        handler_trig_in = 1'b0;
  logic        manual_key = 1'b0;
  logic [1:0]  active_channel = 2'h0;
  logic [7:0]  latency = 8'h02;
  logic        point_done, sweep_done, meas_start, meas_point_mode, sweep_abort, irq;
  logic [3:0]  chan_mask;
  logic [31:0] rd;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          n_start = 0;
  int          n_abort = 0;
  // ---------------------------------------------------------------
  // design, engine, clock
  // ---------------------------------------------------------------
  mtc_trigger #(.STEP_CYC(STEP)) uut (.clk_sys, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .ext_trig_in,
    .handler_trig_in, .manual_key, .point_done, .sweep_done, .active_channel,
    .meas_start, .meas_point_mode, .sweep_abort, .chan_mask, .irq);
  mtc_engine_model eng (.clk_sys, .reset_n, .meas_start, .meas_point_mode,
    .sweep_abort, .latency, .point_done, .sweep_done);
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (meas_start === 1'b1) n_start <= n_start + 1;
    if (sweep_abort === 1'b1) n_abort <= n_abort + 1;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict;
    end
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(logic w, logic [4:0] a, logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic rchk(logic [4:0] a, logic [31:0] exp, string nm);
    acc(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask
  task automatic cmd(int b);
    acc(1'b1, OFF_CMD, 32'(1) << b);
  endtask
  task automatic arm(logic [31:0] c, logic [7:0] l);
    latency <= l;
    acc(1'b1, OFF_CTRL, c);
    cmd(CMD_INIT);
  endtask
  task automatic wait_for(int s, int lim, output int d);
    d = 0;
    for (int i = 1; i <= lim && d == 0; i++) begin
      @(posedge clk_sys);
      if ((s == 0 ? meas_start : s == 1 ? sweep_abort : sweep_done) === 1'b1) d = i;
    end
  endtask
  function automatic logic [31:0] ctl(mtc_src_t s, logic p, logic pt, logic sc, logic c);
    return {26'h000_0000, c, sc, pt, p, s};
  endfunction
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("chan_mask", 32'h0000_000F, 32'(chan_mask));
    rchk(OFF_CTRL, 32'h0000_0000, "ctrl");
    rchk(OFF_DELAY, 32'h0000_0000, "delay");
    rchk(5'h1C, 32'h0000_0000, "unmapped");
    rchk(OFF_STATUS, 32'h0000_0000, "status");
  endtask
  task automatic t_readback;
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, OFF_CTRL, ctl(mtc_src_t'(s), s[0], s[1], !s[0], 1'b0));
      rchk(OFF_CTRL, ctl(mtc_src_t'(s), s[0], s[1], !s[0], 1'b0), "ctrl");
    end
    acc(1'b1, OFF_DELAY, 32'(DLY_MAX));
    rchk(OFF_DELAY, 32'(DLY_MAX), "delay max");
    acc(1'b1, OFF_DELAY, 32'(DLY_MAX) + 32'h0000_0001);
    rchk(OFF_DELAY, 32'(DLY_MAX), "delay clamp");
  endtask
  task automatic t_force_err;
    int n0;
    for (int b = CMD_IMM; b <= CMD_SINGLE; b++) begin
      n0 = n_start;
      cmd(b);
      repeat (3) @(posedge clk_sys);
      chk("start count", 32'(n0), 32'(n_start));
      rchk(OFF_IRQ_STAT, 32'(1) << EV_ERR, "err flag");
      acc(1'b1, OFF_IRQ_CLR, 32'h0000_001F);
    end
  endtask
  task automatic t_bus;
    int n0;
    int d;
    arm(ctl(SRC_BUS, 1'b0, 1'b0, 1'b0, 1'b1), 8'h0A);
    rchk(OFF_STATUS, 32'h0000_0001, "status wait");
    acc(1'b1, OFF_IRQ_EN, 32'h0000_0002);
    n0 = n_start;
    cmd(CMD_BUSTRG);
    repeat (2) @(posedge clk_sys);
    chk("bus starts", 32'(n0 + 1), 32'(n_start));
    chk("irq masked", 32'h0000_0000, 32'(irq));
    wait_for(2, 20, d);
    repeat (2) @(posedge clk_sys);
    rchk(OFF_IRQ_STAT, 32'h0000_0003, "bus events");
    chk("irq set", 32'h0000_0001, 32'(irq));
    acc(1'b1, OFF_IRQ_CLR, 32'h0000_0003);
    @(posedge clk_sys);
    chk("irq clear", 32'h0000_0000, 32'(irq));
  endtask
  task automatic t_imm_single;
    int n0;
    int d;
    arm(ctl(SRC_EXT, 1'b1, 1'b0, 1'b0, 1'b1), 8'h14);
    n0 = n_start;
    cmd(CMD_IMM);
    repeat (2) @(posedge clk_sys);
    chk("imm starts", 32'(n0 + 1), 32'(n_start));
    rchk(OFF_IRQ_STAT, 32'h0000_0009, "imm events");
    wait_for(2, 30, d);
    acc(1'b1, OFF_IRQ_CLR, 32'h0000_001F);
    cmd(CMD_SINGLE);
    rchk(OFF_STATUS, 32'h0000_000A, "single busy");
    rchk(OFF_IRQ_STAT, 32'h0000_0001, "single early");
    wait_for(2, 30, d);
    repeat (2) @(posedge clk_sys);
    rchk(OFF_IRQ_STAT, 32'h0000_0013, "single done");
  endtask
  task automatic t_ext;
    int d;
    for (int k = 0; k < 2; k++) begin
      arm(ctl(SRC_EXT, k == 0, 1'b0, 1'b0, 1'b1), 8'h02);
      acc(1'b1, OFF_DELAY, 32'(3 * k));
      if (k == 1) begin
        @(posedge clk_sys) handler_trig_in <= 1'b1;
        wait_for(0, 8, d);
        chk("wrong edge", 32'h0000_0000, 32'(d));
      end
      @(posedge clk_sys);
      if (k == 0) ext_trig_in <= 1'b1;
      else handler_trig_in <= 1'b0;
      wait_for(0, 30, d);
      chk("ext delay", 32'(3 * k * STEP + 2), 32'(d));
      repeat (4) @(posedge clk_sys);
      ext_trig_in <= 1'b0;
    end
  endtask
  task automatic t_manual;
    int d;
    arm(ctl(SRC_MAN, 1'b0, 1'b1, 1'b0, 1'b1), 8'h03);
    chk("point mode", 32'h0000_0001, 32'(meas_point_mode));
    @(posedge clk_sys) manual_key <= 1'b1;
    wait_for(0, 10, d);
    manual_key <= 1'b0;
    chk("manual fired", 32'h0000_0001, 32'(d != 0));
    repeat (6) @(posedge clk_sys);
    rchk(OFF_STATUS, 32'h0000_0001, "point rewait");
  endtask
  task automatic t_internal;
    int n0;
    acc(1'b1, OFF_CTRL, ctl(SRC_INT, 1'b0, 1'b1, 1'b0, 1'b1));
    n0 = n_start;
    repeat (40) @(posedge clk_sys);
    chk("free run", 32'h0000_0001, 32'(n_start - n0 >= 3));
    chk("point ignored", 32'h0000_0000, 32'(meas_point_mode));
    acc(1'b1, OFF_CTRL, ctl(SRC_INT, 1'b0, 1'b1, 1'b0, 1'b0));
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic t_abort;
    int d;
    int a0;
    arm(ctl(SRC_BUS, 1'b0, 1'b0, 1'b1, 1'b1), 8'h00);
    chk("mask active", 32'h0000_0001, 32'(chan_mask));
    cmd(CMD_BUSTRG);
    @(posedge clk_sys) active_channel <= 2'h2;
    wait_for(1, 6, d);
    chk("chan abort", 32'h0000_0001, 32'(d != 0));
    chk("mask moved", 32'h0000_0004, 32'(chan_mask));
    cmd(CMD_BUSTRG);
    a0 = n_abort;
    acc(1'b1, OFF_CTRL, ctl(SRC_MAN, 1'b0, 1'b0, 1'b1, 1'b1));
    repeat (2) @(posedge clk_sys);
    chk("src abort", 32'(a0 + 1), 32'(n_abort));
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset;
    t_readback;
    t_force_err;
    t_bus;
    t_imm_single;
    t_ext;
    t_manual;
    t_internal;
    t_abort;
    print_verdict;
  end
endmodule
